/* File: src/rtc_flags_pkg.sv */
// package for the century counter and the rtc status/control register
// assumes one 200 MHz clock and an ahb-lite register bus
package rtc_flags_pkg;

  // ***************************************************************
  // register map (word indices; the byte address is four times the index)
  // ***************************************************************
  localparam logic [15:0] STATUS_OFS  = 16'h7ff0;   // rtc_status_and_control
  localparam logic [15:0] CENTURY_OFS = 16'h7ff1;   // century_count_bcd, index form
  localparam logic [15:0] EVENT_OFS   = 16'h7f00;   // event inputs view
  localparam int          ADDR_W      = 16;         // decoded address bits

  // ***************************************************************
  // status register field positions
  // ***************************************************************
  localparam int BIT_WDOG = 7;   // watchdog_expired_flag
  localparam int BIT_ALRM = 6;   // alarm_match_flag
  localparam int BIT_SUPL = 5;   // supply_loss_flag
  localparam int BIT_OSCILLATOR_FAILURE_FLAG = 4;   // oscillator_failure_flag
  localparam int BIT_CAL  = 2;   // calibration output enable
  localparam int BIT_WR   = 1;   // write hold
  localparam int BIT_RD   = 0;   // read hold

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] CENTURY_RST = 8'h00;   // century count after reset
  localparam logic [7:0] STATUS_RST  = 8'h00;   // control bits after reset

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_MHZ        = 200;            // clock rate
  localparam int OSC_START_US   = 5000;           // 5 ms start window
  localparam int OSC_START_CYC  = OSC_START_US * CLK_MHZ;
  localparam int UPD_DELAY_US   = 350;            // rtc_update_delay, plain default
  localparam int UPD_DELAY_CYC  = UPD_DELAY_US * CLK_MHZ;
  localparam int CNT_W          = 21;             // wide enough for both counts

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic wdog;   // watchdog expired event
    logic alrm;   // alarm match event
    logic supl;   // supply fell below supply_switch_threshold
  } event_in_t;

  typedef struct packed {
    logic       wr;      // write strobe
    logic       rd;      // read strobe
    logic [7:0] wdata;   // write data
  } reg_acc_t;

endpackage

/* File: src/rtc_delay_timer.sv */
// one-shot cycle timer: counts down a loaded value, pulses done at zero
// assumes a single clock; reload while busy restarts the count
module rtc_delay_timer
  import rtc_flags_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_q, cnt_d;   // cycles remaining
  logic             busy_d, done_d;   // next status

  // ***************************************************************
  // count-down
  // ***************************************************************
  // next value: restart on start, count while busy
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy;
    done_d = 1'b0;
    if (start) begin
      cnt_d  = load;
      busy_d = 1'b1;
    end else if (busy) begin
      if (cnt_q <= CNT_W'(1)) begin   // last cycle
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy  <= busy_d;
      done  <= done_d;
    end
  end

endmodule

/* File: src/rtc_century_bcd.sv */
// bcd century counter, two digits 00..99, wraps at 99
// assumes load has priority over increment
module rtc_century_bcd
  import rtc_flags_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       inc,
  output logic [7:0]      value_q
);

  logic [7:0] value_d;   // next count

  // ***************************************************************
  // next value
  // ***************************************************************
  always_comb begin
    value_d = value_q;
    if (load) begin
      value_d = load_val;
    end else if (inc) begin
      if (value_q[3:0] >= 4'h9) begin          // units roll over
        value_d[3:0] = 4'h0;
        value_d[7:4] = (value_q[7:4] >= 4'h9) ? 4'h0 : value_q[7:4] + 4'h1;
      end else begin
        value_d[3:0] = value_q[3:0] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) value_q <= CENTURY_RST;
    else     value_q <= value_d;
  end

endmodule

/* File: src/rtc_flags_top.sv */
// century counter and rtc status/control register behind ahb-lite
// assumes: RST models power-up; OSC_RUN/OSC_EN come from the oscillator;
// century increments come from the time keeping chain outside this block
// registers are decoded by word index: the byte address is four times it
//
// Behaviour
// - century units digit is bcd 0..9
// - century tens digit bcd, range 0..9
// - osc fail set if not running at 5ms
// - osc fail sticky, cleared only by host
// - osc fail clear shows after update delay
// - supply loss set on drop, read clears
module rtc_flags_top
  import rtc_flags_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        OSC_EN,
  input  wire logic        OSC_RUN,
  input  wire logic        CENTURY_TICK,
  input  wire logic        WDOG_EVT,
  input  wire logic        ALRM_EVT,
  input  wire logic        SUPPLY_LOW,
  output logic             CAL_OUT_EN,
  output logic             WRITE_HOLD,
  output logic             READ_HOLD,
  output logic             TIME_LOAD
);

  // ***************************************************************
  // bus address phase capture
  // ***************************************************************
  logic              dp_wr_q, dp_wr_d;       // write data phase pending
  logic              dp_rd_q, dp_rd_d;       // read data phase pending
  logic [ADDR_W-1:0] dp_addr_q, dp_addr_d;   // latched address
  logic [31:0]       rdata_q, rdata_d;       // read data register
  logic              addr_ok;                // valid single transfer
  logic [ADDR_W-1:0] addr_idx;               // word index of the address phase
  logic [7:0]        status_view;            // status as software sees it
  logic [7:0]        century_view;           // century as software sees it

  // registers sit one per word: byte lanes and the two low address bits
  // are ignored, so a host sees each register at four times its index
  assign addr_ok  = HSEL && HREADY && HTRANS[1];
  assign addr_idx = HADDR[ADDR_W+1:2];

  // next address-phase state; read data is produced one cycle after capture
  // the read data is sampled here, in the address phase, so that a status
  // read returns the flags as they stood before the read clears them
  always_comb begin
    dp_wr_d   = addr_ok && HWRITE;
    dp_rd_d   = addr_ok && !HWRITE;
    dp_addr_d = addr_ok ? addr_idx : dp_addr_q;
    rdata_d   = rdata_q;
    if (addr_ok && !HWRITE) begin
      unique case (addr_idx)
        STATUS_OFS:  rdata_d = {24'h0, status_view};
        CENTURY_OFS: rdata_d = {24'h0, century_view};
        EVENT_OFS:   rdata_d = {29'h0, SUPPLY_LOW, ALRM_EVT, WDOG_EVT};
        default:     rdata_d = 32'h0;   // unmapped reads zero, still okay
      endcase
    end
  end

  // registers only
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= '0;
      rdata_q   <= 32'h0;
    end else begin
      dp_wr_q   <= dp_wr_d;
      dp_rd_q   <= dp_rd_d;
      dp_addr_q <= dp_addr_d;
      rdata_q   <= rdata_d;
    end
  end

  // zero-wait slave: always ready, always okay
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end
  assign HRDATA = rdata_q;

  // ***************************************************************
  // register write strobes
  // ***************************************************************
  reg_acc_t status_acc;    // status register access
  logic     century_wr;    // century register write

  // writes act in the data phase, when hwdata stands; the read side acts in
  // the address phase so that the clear lines up with the captured read data
  assign status_acc = '{
    wr:    dp_wr_q && (dp_addr_q == STATUS_OFS),
    rd:    addr_ok && !HWRITE && (addr_idx == STATUS_OFS),
    wdata: HWDATA[7:0]
  };
  assign century_wr = dp_wr_q && (dp_addr_q == CENTURY_OFS);

  // ***************************************************************
  // flags and control bits
  // ***************************************************************
  logic       wdog_q, wdog_d;       // watchdog_expired_flag
  logic       alrm_q, alrm_d;       // alarm_match_flag
  logic       supl_q, supl_d;       // supply_loss_flag
  logic       oscillator_failure_flag_q, oscillator_failure_flag_d;       // oscillator_failure_flag, visible copy
  logic       cal_q, cal_d;         // calibration output enable
  logic       wr_q, wr_d;           // write hold
  logic       rd_q, rd_d;           // read hold
  logic       load_q, load_d;       // one-cycle transfer into counters
  logic       chk_q, chk_d;         // start window still open
  logic       oscillator_failure_flag_pend_q, oscillator_failure_flag_pend_d;   // clear waiting on update delay
  logic [7:0] century_shadow_q, century_shadow_d;   // user-written value
  logic [7:0] century_held_q, century_held_d;       // frozen read copy
  logic [7:0] century_cnt;          // live counter
  logic       win_done, upd_done;   // timer results
  logic       upd_start;            // timer start: start window after reset, or restart for a flag clear
  event_in_t  evt;                  // incoming events

  assign evt = '{wdog: WDOG_EVT, alrm: ALRM_EVT, supl: SUPPLY_LOW};

  // bit 3 has no storage and always reads zero
  assign status_view = {wdog_q, alrm_q, supl_q, oscillator_failure_flag_q, 1'b0, cal_q, wr_q, rd_q};
  assign century_view = rd_q ? century_held_q : (wr_q ? century_shadow_q : century_cnt);

  // next flag state; a new event in the clearing cycle wins
  // watchdog and alarm flags clear on a status read as the supply flag does
  always_comb begin
    wdog_d  = wdog_q;
    alrm_d  = alrm_q;
    supl_d  = supl_q;
    cal_d   = cal_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    oscillator_failure_flag_d  = oscillator_failure_flag_q;
    chk_d   = chk_q;
    oscillator_failure_flag_pend_d = oscillator_failure_flag_pend_q;
    load_d  = 1'b0;
    if (status_acc.rd) begin
      wdog_d = 1'b0;                     // read clears watchdog flag
      alrm_d = 1'b0;                     // read clears alarm flag
      supl_d = 1'b0;
    end
    if (evt.wdog) wdog_d = 1'b1;
    if (evt.alrm) alrm_d = 1'b1;
    if (evt.supl) supl_d = 1'b1;
    if (status_acc.wr) begin
      cal_d = status_acc.wdata[BIT_CAL];
      wr_d  = status_acc.wdata[BIT_WR];
      rd_d  = status_acc.wdata[BIT_RD];
      if (wr_q && !status_acc.wdata[BIT_WR]) begin
        load_d = 1'b1;
      end
      if (!status_acc.wdata[BIT_OSCILLATOR_FAILURE_FLAG] && oscillator_failure_flag_q) begin
        oscillator_failure_flag_pend_d = 1'b1;
      end
    end
    // a pending clear takes effect once the update delay has run out
    if (upd_done && oscillator_failure_flag_pend_q) begin
      oscillator_failure_flag_d      = 1'b0;
      oscillator_failure_flag_pend_d = 1'b0;
    end
    // start window: a running oscillator closes it early; placed after the
    // clear so that a failure found in the same cycle still sets the flag
    if (chk_q && OSC_RUN) begin
      chk_d = 1'b0;
    end else if (chk_q && win_done) begin
      chk_d = 1'b0;
      if (OSC_EN) oscillator_failure_flag_d = 1'b1;
    end
  end

  // registers; oscillator fail flag is not cleared by reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wdog_q      <= 1'b0;
      alrm_q      <= 1'b0;
      supl_q      <= 1'b0;
      cal_q       <= STATUS_RST[BIT_CAL];
      wr_q        <= STATUS_RST[BIT_WR];
      rd_q        <= STATUS_RST[BIT_RD];
      load_q      <= 1'b0;
      chk_q       <= 1'b1;
      oscillator_failure_flag_pend_q <= 1'b0;
    end else begin
      wdog_q      <= wdog_d;
      alrm_q      <= alrm_d;
      supl_q      <= supl_d;
      cal_q       <= cal_d;
      wr_q        <= wr_d;
      rd_q        <= rd_d;
      load_q      <= load_d;
      chk_q       <= chk_d;
      oscillator_failure_flag_pend_q <= oscillator_failure_flag_pend_d;
    end
  end

  // battery-backed flag: RST models power-up, so this flop has no reset and
  // keeps its value across it; in simulation it stays unknown until the
  // start window sets it; a host clear only starts once the flag reads as set, so benches mask the bit
  // limitation: with no backup cell modelled the flag starts undefined
  always_ff @(posedge CLK) begin
    oscillator_failure_flag_q <= oscillator_failure_flag_d;
  end

  // ***************************************************************
  // century shadow and frozen copy
  // ***************************************************************
  // host writes land in the shadow only; the live counter takes them when
  // the write hold is released, so a half-written time never reaches it
  // the frozen copy is taken on the rising read hold, not on every cycle
  always_comb begin
    century_shadow_d = century_wr ? HWDATA[7:0] : century_shadow_q;
    century_held_d   = (status_acc.wr && status_acc.wdata[BIT_RD] && !rd_q)
                       ? century_cnt : century_held_q;
  end

  // registers only
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      century_shadow_q <= CENTURY_RST;
      century_held_q   <= CENTURY_RST;
    end else begin
      century_shadow_q <= century_shadow_d;
      century_held_q   <= century_held_d;
    end
  end

  // ***************************************************************
  // sub-blocks
  // ***************************************************************
  // live counter; frozen while write hold is set
  // a tick that arrives while the hold stands is dropped, not queued
  rtc_century_bcd u_cent (
    .clk      (CLK),
    .rst      (RST),
    .load     (load_q),
    .load_val (century_shadow_q),
    .inc      (CENTURY_TICK && !wr_q),
    .value_q  (century_cnt)
  );

  // one timer: start window at reset release, then the update delay
  // trade-off: sharing one counter saves a register, so a clear written while
  // the start window is still open waits for the window to end
  logic start_win_q;   // first cycle after reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) start_win_q <= 1'b1;
    else     start_win_q <= 1'b0;
  end

  // a clear restarts the delay only once the start window has closed
  assign upd_start = start_win_q ||
                     (status_acc.wr && !status_acc.wdata[BIT_OSCILLATOR_FAILURE_FLAG] && oscillator_failure_flag_q && !chk_q);

  rtc_delay_timer u_tmr (
    .clk   (CLK),
    .rst   (RST),
    .start (upd_start),
    .load  (start_win_q ? CNT_W'(OSC_START_CYC) : CNT_W'(UPD_DELAY_CYC)),
    .busy  (),
    .done  (upd_done)
  );
  assign win_done = upd_done && chk_q;

  // ***************************************************************
  // outputs
  // ***************************************************************
  // outputs take the next values, so they change in the same cycle as the
  // state flops and never lag one cycle behind the register contents
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CAL_OUT_EN <= 1'b0;
      WRITE_HOLD <= 1'b0;
      READ_HOLD  <= 1'b0;
      TIME_LOAD  <= 1'b0;
    end else begin
      CAL_OUT_EN <= cal_d;
      WRITE_HOLD <= wr_d;
      READ_HOLD  <= rd_d;
      TIME_LOAD  <= load_d;
    end
  end

endmodule

/* File: sim/rtc_flags_monitor.sv */
// checker for the century and status registers, watching the top ports only
// assumes word transfers at a byte address four times the register index
module rtc_flags_monitor
  import rtc_flags_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        SUPPLY_LOW,
  input wire logic        WRITE_HOLD,
  input wire logic        TIME_LOAD
);
  // ****************************************************************
  // bus decode helpers
  // ****************************************************************
  wire logic take    = HSEL & HREADY & HTRANS[1];          // accepted transfer
  wire logic at_stat = HADDR[17:2] == STATUS_OFS;          // status word hit
  wire logic rstat   = take & !HWRITE & at_stat;           // status read taken
  logic      rd_cent_q, rd_cent_d;                         // century data phase
  logic      wr_stat_q, wr_stat_d;                         // status write data phase
  logic      hold_q, hold_d;                               // last written hold bit
  // next values of the helpers
  always_comb begin
    rd_cent_d = take & !HWRITE & (HADDR[17:2] == CENTURY_OFS);
    wr_stat_d = take & HWRITE & at_stat;
    hold_d    = wr_stat_q ? HWDATA[BIT_WR] : hold_q;       // data phase carries it
  end
  // helper registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_cent_q <= 1'b0;
      wr_stat_q <= 1'b0;
      hold_q    <= 1'b0;
    end else begin
      rd_cent_q <= rd_cent_d;
      wr_stat_q <= wr_stat_d;
      hold_q    <= hold_d;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ****************************************************************
  // assertions
  // ****************************************************************
  hresp_okay_a: assert property (HRESP == 1'b0)
    else $error("slave answered with an error response");
  ready_high_a: assert property (HREADYOUT == 1'b1)
    else $error("slave inserted a wait state");
  upper_zero_a: assert property (rd_cent_q |-> HRDATA[31:8] == 24'h0)
    else $error("century read carries bits above the byte");
  century_bcd_a: assert property (rd_cent_q |-> HRDATA[3:0] <= 4'h9 && HRDATA[7:4] <= 4'h9)
    else $error("century digit outside 0 to 9");
  hold_follow_a: assert property (wr_stat_q |=> ##[0:1] WRITE_HOLD == hold_q)
    else $error("write hold does not follow the written bit");
  load_cause_a: assert property ($fell(WRITE_HOLD) |-> ##[0:1] TIME_LOAD)
    else $error("no time load after write hold release");
  load_pulse_a: assert property (TIME_LOAD |=> !TIME_LOAD)
    else $error("time load longer than one cycle");
  supply_set_a: assert property (SUPPLY_LOW [*3] ##1 rstat |=> HRDATA[BIT_SUPL])
    else $error("supply loss flag not set after low supply");
  supply_clear_a: assert property ((!SUPPLY_LOW throughout (rstat ##3 rstat)) |=> !HRDATA[BIT_SUPL])
    else $error("supply loss flag survived a status read");
  cover property (rd_cent_q);
  cover property ($fell(WRITE_HOLD));
  cover property (rstat && SUPPLY_LOW);
endmodule

bind rtc_flags_top rtc_flags_monitor rtc_flags_monitor_inst (.CLK(CLK), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SUPPLY_LOW(SUPPLY_LOW),
  .WRITE_HOLD(WRITE_HOLD), .TIME_LOAD(TIME_LOAD));

/* File: sim/rtc_host_model.sv */
// host processor model: single-word ahb-lite master for the register block
// assumes hready is the slave's hreadyout; waits only end by the bench watchdog
module rtc_host_model
  import rtc_flags_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'hffff_ffff;
  end
  // one transfer; a status read clears the event flags, a written zero clears the oscillator flag
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {14'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~{24'h0, wd};  // released data lines do not keep the old value
  endtask
endmodule

/* File: sim/test_rtc_flags_top.sv */
// self-checking bench for the century and status register block
// assumes the host model drives the bus; oscillator held enabled and running
module test_rtc_flags_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_flags_pkg::*;
  typedef struct packed {logic [7:0] wv; logic [1:0] n; logic [7:0] ev;} row_t;
  logic clk = 1'b0, rst = 1'b1, osc_en = 1'b1, osc_run = 1'b1, tick = 1'b0;
  logic wdog = 1'b0, alrm = 1'b0, low = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, cal, whold, rhold, tload;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_count = 0, samples_checked = 0, loads = 0, l0;
  row_t rows[6] = '{'{8'h00, 2'd1, 8'h01}, '{8'h09, 2'd1, 8'h10}, '{8'h19, 2'd1, 8'h20},
                    '{8'h99, 2'd1, 8'h00}, '{8'h98, 2'd2, 8'h00}, '{8'h45, 2'd0, 8'h45}};
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // count time load pulses
  always @(posedge clk) if (tload === 1'b1) loads <= loads + 1;
  rtc_flags_top rtc_flags_top_inst (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .OSC_EN(osc_en), .OSC_RUN(osc_run),
    .CENTURY_TICK(tick), .WDOG_EVT(wdog), .ALRM_EVT(alrm), .SUPPLY_LOW(low), .CAL_OUT_EN(cal),
    .WRITE_HOLD(whold), .READ_HOLD(rhold), .TIME_LOAD(tload));
  rtc_host_model rtc_host_model_inst (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask
  // verdict and end of run
  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one century increment pulse
  task automatic pulse();
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask
  // status read with the oscillator flag masked, it is undefined until set
  task automatic rstat(input logic [31:0] exp, input string name);
    rtc_host_model_inst.xfer(1'b0, STATUS_OFS, 8'h00, rd);
    check(name, rd & 32'hffff_ffef, exp);
  endtask
  // watchdog against a hung handshake
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    check("reset outputs", {26'h0, hresp, hreadyout, cal, whold, rhold, tload}, 32'h10);
    rtc_host_model_inst.xfer(1'b0, CENTURY_OFS, 8'h00, rd);
    check("century reset", rd, {24'h0, CENTURY_RST});
    // a written value reaches the counter only when the write hold is released
    foreach (rows[i]) begin
      rtc_host_model_inst.xfer(1'b1, STATUS_OFS, 8'h02, rd);
      rtc_host_model_inst.xfer(1'b1, CENTURY_OFS, rows[i].wv, rd);
      rtc_host_model_inst.xfer(1'b1, STATUS_OFS, 8'h00, rd);
      repeat (rows[i].n) pulse();
      rtc_host_model_inst.xfer(1'b0, CENTURY_OFS, 8'h00, rd);
      check("century", rd, {24'h0, rows[i].ev});
    end
    // control bits, then release of write hold loads the counters
    rtc_host_model_inst.xfer(1'b1, STATUS_OFS, 8'h07, rd);
    repeat (3) @(posedge clk);
    check("control outputs", {29'h0, cal, whold, rhold}, 32'h7);
    rstat(32'h07, "control readback");
    l0 = loads;
    rtc_host_model_inst.xfer(1'b1, STATUS_OFS, 8'h00, rd);
    repeat (4) @(posedge clk);
    check("time load pulses", 32'(loads - l0), 32'h1);
    check("hold released", {31'h0, whold}, 32'h0);
    // read hold shows the copy taken when it was set, ticks go on behind it
    rtc_host_model_inst.xfer(1'b1, STATUS_OFS, 8'h01, rd);
    pulse();
    rtc_host_model_inst.xfer(1'b0, CENTURY_OFS, 8'h00, rd);
    check("century held", rd, 32'h45);
    rtc_host_model_inst.xfer(1'b1, STATUS_OFS, 8'h00, rd);
    rtc_host_model_inst.xfer(1'b0, CENTURY_OFS, 8'h00, rd);
    check("century after hold", rd, 32'h46);
    // events set flags; a read clears them unless the cause is still present
    @(posedge clk) {wdog, alrm, low} <= 3'b111;
    @(posedge clk) {wdog, alrm} <= 2'b00;
    repeat (2) @(posedge clk);
    rstat(32'he0, "flags set");
    low <= 1'b0;
    repeat (4) @(posedge clk);
    rstat(32'h20, "supply flag held");
    rstat(32'h00, "flags cleared");
    // unmapped word reads zero
    rtc_host_model_inst.xfer(1'b0, 16'h0010, 8'h00, rd);
    check("unmapped", rd, 32'h0);
    // second reset in mid-run returns the century to zero
    rtc_host_model_inst.xfer(1'b1, CENTURY_OFS, 8'h55, rd);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rtc_host_model_inst.xfer(1'b0, CENTURY_OFS, 8'h00, rd);
    check("century after reset", rd, 32'h0);
    conclude();
  end
endmodule
